/* File: bench/icp_checker_sva.sv */
`timescale 1ns/1ns
module icp_checker (
   input wire logic         ref_clk_in,
   input wire logic         reset_n_in,
   input wire logic         software_break_in,
   input wire logic         ack_in,
   input wire logic         clear_iflag_in,
   input wire logic         take_out,
   input icp_pkg::icp_vec_s vec_out,
   input wire logic         iflag_out,
   input wire logic         irq_out
);
   import icp_pkg::*;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   AST_ACCEPT:
      assert property (ack_in && take_out |=> vec_out.valid)
      else $error("accept gave no vector");
   AST_NO_SPUR:
      assert property (!(ack_in && take_out) |=> !vec_out.valid)
      else $error("vector without accept");
   AST_IFLAG:
      assert property (vec_out.valid |-> iflag_out)
      else $error("disable flag not set on accept");
   AST_BREAK:
      assert property (software_break_in |-> ##[1:2] take_out)
      else $error("break not offered");
   AST_CLI:
      assert property (clear_iflag_in && !ack_in |=> !iflag_out)
      else $error("disable flag not cleared");
   AST_IRQ_TAKE:
      assert property (irq_out && !iflag_out |-> take_out)
      else $error("unmasked request not offered");
   AST_PUSH:
      assert property (vec_out.valid |->
         vec_out.push == (vec_out.addr != VEC_RESET))
      else $error("push wrong");
   AST_VEC:
      assert property (vec_out.valid |-> vec_out.addr[0] == 1'h0 &&
         vec_out.addr >= VEC_BREAK && vec_out.addr <= VEC_RESET)
      else $error("vector outside table");
endmodule // icp_checker

bind icp_interrupt_controller icp_checker CHK (.ref_clk_in, .reset_n_in,
   .software_break_in, .ack_in, .clear_iflag_in, .take_out, .vec_out,
   .iflag_out, .irq_out);

/* File: bench/icp_cpu_model.sv */
`timescale 1ns/1ns
module icp_cpu_model (
   input  wire logic       ref_clk_in,
   input  wire logic       go_in,
   input  wire logic [1:0] delay_in,
   input  wire logic       take_in,
   output logic            ack_out
);
   logic [1:0] wait_cnt;
   // a take that drops before the delay runs out is never answered
   always_ff @(posedge ref_clk_in) begin
      if (!go_in || !take_in || ack_out) begin
         wait_cnt <= 2'h0;
         ack_out  <= 1'h0;
      end else if (wait_cnt == delay_in) begin
         ack_out <= 1'h1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule // icp_cpu_model

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
   import icp_pkg::*;
   localparam logic [15:0] VT [15] = '{16'hFFFA, 16'hFFF8, 16'hFFF6,
      16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE, 16'hFFEC, 16'hFFEA,
      16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2, 16'hFFE0, 16'hFFDE};
   logic        clk   = 1'h0;
   logic        rst_n = 1'h0;
   icp_bus_s    bus   = '0;
   icp_vec_s    vec;
   logic [7:0]  rdata, got;
   logic [7:0]  key   = 8'hFF;
   logic [5:0]  ext   = 6'h00;
   logic [2:0]  tovf  = 3'h0;
   logic [1:0]  dly   = 2'h0;
   logic [15:0] m;
   logic        hif = 1'h0, hoe = 1'h0, rxd = 1'h0, txd = 1'h0;
   logic        cntp = 1'h0, software_break = 1'h0, cli = 1'h0, go = 1'h0;
   logic        ssel = 1'h1, ack, take, iflag, irq;
   logic        txe  = 1'h0;
   logic [7:0]  kdir = 8'h00;
   int          fails = 0, samples_checked = 0, cyc = 0;

   always #4 clk = ~clk;

   icp_interrupt_controller DUT (.ref_clk_in(clk), .reset_n_in(rst_n),
      .bus_in(bus), .rdata_out(rdata), .ext_pin_in(ext),
      .counter_pin_in(cntp), .key_wakeup_port_in(key),
      .key_wakeup_dir_in(kdir), .host_input_full_in(hif),
      .host_output_empty_in(hoe), .serial_sel_in(ssel),
      .sio_rx_done_in(rxd), .sio_tx_done_in(txd),
      .sio_tx_empty_in(txe), .timer_ovf_in(tovf),
      .software_break_in(software_break), .ack_in(ack), .clear_iflag_in(cli),
      .take_out(take), .vec_out(vec), .iflag_out(iflag),
      .irq_out(irq));
   icp_cpu_model CPU (.ref_clk_in(clk), .go_in(go), .delay_in(dly),
      .take_in(take), .ack_out(ack));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         fails++;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'h1, 1'h0};
      @(posedge clk) bus <= '0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input string n, input logic [5:0] a,
                       input logic [7:0] e);
      @(posedge clk) bus <= '{a, 8'h00, 1'h0, 1'h1};
      @(posedge clk) bus <= '0;
      #1 got = rdata;
      chk(n, {8'h00, e}, {8'h00, got});
   endtask
   task automatic src(input int i, input logic v);
      case (i)
         0: hif <= v;
         1: hoe <= v;
         2: ext[0] <= v;
         3: rxd <= v;
         4: txd <= v;
         5, 6, 7: tovf[i-5] <= v;
         8: cntp <= v;
         14: key[0] <= !v;
         15: software_break <= v;
         default: ext[i-8] <= v;
      endcase
   endtask
   task automatic pulse(input int i);
      @(posedge clk) src(i, 1'h1);
      @(posedge clk) src(i, 1'h0);
   endtask
   task automatic clr_flag();
      @(posedge clk) cli <= 1'h1;
      @(posedge clk) cli <= 1'h0;
   endtask
   task automatic accept(input logic [15:0] e, input logic p);
      go <= 1'h1;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (vec.valid === 1'h1) break;
      end
      go <= 1'h0;
      chk("vector", e, vec.addr);
      chk("push", {15'h0, p}, {15'h0, vec.push});
      chk("iflag", 16'h1, {15'h0, iflag});
   endtask
   task automatic done(input string n);
      $display("test %s finished", n);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         fails++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      accept(VEC_RESET, 1'h0);
      done("reset");
      for (int i = 0; i < NSRC; i++) begin
         m = 16'h1 << i;
         wr(ADR_EN1, m[7:0]);
         wr(ADR_EN2, m[15:8]);
         clr_flag();
         pulse(i);
         accept(VT[i], 1'h1);
         rchk("req", i < 8 ? ADR_REQ1 : ADR_REQ2, 8'h00);
      end
      done("sources");
      wr(ADR_EN1, 8'hFF);
      wr(ADR_EN2, 8'h7F);
      clr_flag();
      @(posedge clk) hif <= 1'h1;
      tovf <= 3'h2;
      @(posedge clk) hif <= 1'h0;
      tovf <= 3'h0;
      dly <= 2'h3;
      accept(VEC_FIRST, 1'h1);
      clr_flag();
      accept(VT[SRC_TM1], 1'h1);
      done("priority");
      pulse(SRC_TMX);
      repeat (6) @(posedge clk);
      #1 chk("masked", 16'h0, {15'h0, take});
      chk("irq", 16'h1, {15'h0, irq});
      pulse(15);
      accept(VEC_BREAK, 1'h1);
      clr_flag();
      accept(VT[SRC_TMX], 1'h1);
      done("break");
      wr(ADR_EN1, 8'h55);
      rchk("enable", ADR_EN1, 8'h55);
      wr(ADR_EN1, 8'h00);
      rchk("enable", ADR_EN1, 8'h00);
      wr(ADR_REQ1, 8'hFF);
      rchk("req", ADR_REQ1, 8'h00);
      rchk("hole", 6'h00, 8'h00);
      wr(ADR_EDGE, 8'h01);
      rchk("edge req", ADR_REQ1, 8'h04);
      wr(ADR_REQ1, 8'h04);
      rchk("req", ADR_REQ1, 8'h00);
      pulse(SRC_EXT0);
      repeat (6) @(posedge clk);
      rchk("fall req", ADR_REQ1, 8'h04);
      wr(ADR_REQ1, 8'h04);
      @(posedge clk) ssel <= 1'h0;
      pulse(SRC_SRX);
      repeat (3) @(posedge clk);
      rchk("serial", ADR_REQ1, 8'h00);
      @(posedge clk) ssel <= 1'h1;
      txe <= 1'h1;
      @(posedge clk) txe <= 1'h0;
      repeat (2) @(posedge clk);
      rchk("tx empty", ADR_REQ1, 8'h10);
      wr(ADR_REQ1, 8'h10);
      // an output-mode pin going low must not wake
      @(posedge clk) kdir <= 8'h02;
      key <= 8'hFD;
      repeat (6) @(posedge clk);
      rchk("key out", ADR_REQ2, 8'h00);
      @(posedge clk) key <= 8'hFF;
      repeat (4) @(posedge clk);
      kdir <= 8'h00;
      wr(ADR_CTRL, 8'h00);
      rchk("ctrl", ADR_CTRL, 8'h00);
      wr(ADR_CTRL, 8'h01);
      rchk("ctrl", ADR_CTRL, 8'h01);
      wr(ADR_EDGE, 8'h41);
      rchk("cntr edge", ADR_REQ2, 8'h01);
      rchk("edge", ADR_EDGE, 8'h41);
      done("registers");
      tally_and_finish();
   end
endmodule // testbench

/* File: core/icp_interrupt_controller.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - maskable interrupt needs request 1, enable 1 and disable flag 0
// - software can set or clear every enable bit
// - software clears request bits; writing the request registers cannot set them
// - disable flag masks every maskable source; reset, software break and irq_out ignore it
// - accept: push state (not on reset), set disable flag, clear request, load vector
// - sixteen sources: eight external, seven internal, one software
// - fixed priority from reset down to software break
// - two-byte vectors descending by priority, reset FFFC, break FFDC
// - host write sets input-full, host read sets output-empty request
// - external pins and counter pin set request on selected edge
// - serial requests set on completion (transmit also on tx empty), only while serial selected
// - each timer overflow sets its own request bit
// - key wakeup request when AND of input-mode port pins falls
// - switching edge select from rising to falling sets the request
// - break and reset need no request or enable; reset is highest

////////////////////////////////////////////////////////////////////////
module icp_edge_det (
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   input  wire logic pin_in,
   input  wire logic falling_in,
   output logic      edge_out
);
   logic sync1;
   logic sync2;
   logic prev;

   // sync1 feeds sync2 only
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev  <= 1'b0;
      end else begin
         sync1 <= pin_in;
         sync2 <= sync1;
         prev  <= sync2;
      end
   end

   assign edge_out = falling_in ? (prev & ~sync2) : (~prev & sync2);
endmodule // icp_edge_det

////////////////////////////////////////////////////////////////////////
module icp_interrupt_controller (
   input  wire logic            ref_clk_in,
   input  wire logic            reset_n_in,
   input  icp_pkg::icp_bus_s    bus_in,
   output logic [7:0]           rdata_out,
   input  wire logic [5:0]      ext_pin_in,
   input  wire logic            counter_pin_in,
   input  wire logic [7:0]      key_wakeup_port_in,
   input  wire logic [7:0]      key_wakeup_dir_in,
   input  wire logic            host_input_full_in,
   input  wire logic            host_output_empty_in,
   input  wire logic            serial_sel_in,
   input  wire logic            sio_rx_done_in,
   input  wire logic            sio_tx_done_in,
   input  wire logic            sio_tx_empty_in,
   input  wire logic [2:0]      timer_ovf_in,
   input  wire logic            software_break_in,
   input  wire logic            ack_in,
   input  wire logic            clear_iflag_in,
   output logic                 take_out,
   output icp_pkg::icp_vec_s    vec_out,
   output logic                 iflag_out,
   output logic                 irq_out
);
   import icp_pkg::*;

   logic [1:0]      rst_pipe;
   logic            rst_n;
   logic [NSRC-1:0] req;
   logic [NSRC-1:0] en;
   logic [NPIN-1:0] edge_sel;
   logic            iflag;
   logic            reset_pend;
   logic            brk_pend;
   logic [NPIN-1:0] pin_edge;
   logic [NPIN-1:0] pins;
   logic [7:0]      key_s1;
   logic [7:0]      key_s2;
   logic            key_and_prev;
   logic            key_and;
   logic [NSRC-1:0] hw_set;
   logic [NSRC-1:0] sw_clr;
   logic [NSRC-1:0] ack_clr;
   logic [NSRC-1:0] pend;
   logic [3:0]      sel;
   logic            any_pend;
   logic            accept;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   ////////////////////////////////////////////////////////////////////
   assign pins = {counter_pin_in, ext_pin_in};

   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : g_pin
         icp_edge_det u_det (
            .ref_clk_in (ref_clk_in),
            .rst_n_in   (rst_n),
            .pin_in     (pins[g]),
            .falling_in (edge_sel[g]),
            .edge_out   (pin_edge[g])
         );
      end
   endgenerate

   // only pins in input mode take part; output pins count as high
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         key_s1       <= 8'hFF;
         key_s2       <= 8'hFF;
         key_and_prev <= 1'b1;
      end else begin
         key_s1       <= key_wakeup_port_in;
         key_s2       <= key_s1;
         key_and_prev <= key_and;
      end
   end
   assign key_and = &(key_s2 | key_wakeup_dir_in);

   ////////////////////////////////////////////////////////////////////
   logic wr_edge;
   logic [NPIN-1:0] to_falling;

   assign wr_edge    = bus_in.wr && (bus_in.addr == ADR_EDGE);
   assign to_falling = wr_edge ? (bus_in.wdata[NPIN-1:0] & ~edge_sel)
                               : {NPIN{1'b0}};

   always_comb begin
      hw_set           = '0;
      hw_set[SRC_HIF]  = host_input_full_in;
      hw_set[SRC_HOE]  = host_output_empty_in;
      hw_set[SRC_EXT0] = pin_edge[0] | to_falling[0];
      hw_set[SRC_SRX]  = serial_sel_in & sio_rx_done_in;
      hw_set[SRC_STX]  = serial_sel_in &
                         (sio_tx_done_in | sio_tx_empty_in);
      hw_set[SRC_TMX]  = timer_ovf_in[0];
      hw_set[SRC_TM1]  = timer_ovf_in[1];
      hw_set[SRC_TM2]  = timer_ovf_in[2];
      hw_set[SRC_CNTR] = pin_edge[PIN_CNTR] | to_falling[PIN_CNTR];
      hw_set[SRC_EXT1 +: 5] = pin_edge[5:1] | to_falling[5:1];
      hw_set[SRC_KEY]  = key_and_prev & ~key_and;
   end

   // write one clears; a write to a request register never sets a request
   always_comb begin
      sw_clr = '0;
      if (bus_in.wr && bus_in.addr == ADR_REQ1) begin
         sw_clr[7:0] = bus_in.wdata;
      end else if (bus_in.wr && bus_in.addr == ADR_REQ2) begin
         sw_clr[NSRC-1:8] = bus_in.wdata[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign pend     = req & en & {NSRC{~iflag}};
   assign any_pend = |pend;

   always_comb begin
      sel = 4'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            sel = 4'(i);
         end
      end
   end

   assign take_out = reset_pend | brk_pend | any_pend;
   assign accept   = ack_in & take_out;
   assign irq_out  = |(req & en);

   always_comb begin
      ack_clr = '0;
      if (accept && !reset_pend && !any_pend) begin
         ack_clr = '0;
      end else if (accept && !reset_pend) begin
         ack_clr[sel] = 1'b1;
      end
   end

   // a hardware set in the same cycle as any clear wins
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         req <= REQ_RST;
      end else begin
         req <= (req & ~(sw_clr | ack_clr)) | hw_set;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         en <= EN_RST;
      end else if (bus_in.wr && bus_in.addr == ADR_EN1) begin
         en[7:0] <= bus_in.wdata;
      end else if (bus_in.wr && bus_in.addr == ADR_EN2) begin
         en[NSRC-1:8] <= bus_in.wdata[6:0];
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         edge_sel <= EDGE_RST;
      end else if (wr_edge) begin
         edge_sel <= bus_in.wdata[NPIN-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // break is latched so that it waits behind reset, never lost
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         reset_pend <= 1'b1;
         brk_pend   <= 1'b0;
      end else begin
         if (accept) begin
            reset_pend <= 1'b0;
         end
         if (software_break_in) begin
            brk_pend <= 1'b1;
         end else if (accept && !reset_pend && !any_pend) begin
            brk_pend <= 1'b0;
         end
      end
   end

   // order: reset, then maskable by index, break last
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         vec_out <= '0;
      end else if (accept) begin
         vec_out.valid <= 1'b1;
         vec_out.push  <= ~reset_pend;
         if (reset_pend) begin
            vec_out.addr <= VEC_RESET;
         end else if (any_pend) begin
            vec_out.addr <= VEC_FIRST - 16'({sel, 1'b0});
         end else begin
            vec_out.addr <= VEC_BREAK;
         end
      end else begin
         vec_out.valid <= 1'b0;
         vec_out.push  <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         iflag <= IFLAG_RST;
      end else if (accept) begin
         iflag <= 1'b1;
      end else if (clear_iflag_in) begin
         iflag <= 1'b0;
      end else if (bus_in.wr && bus_in.addr == ADR_CTRL) begin
         iflag <= bus_in.wdata[0];
      end
   end
   assign iflag_out = iflag;

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_out <= 8'h00;
      end else if (!bus_in.rd) begin
         rdata_out <= 8'h00;
      end else if (bus_in.addr == ADR_CTRL) begin
         rdata_out <= {7'h00, iflag};
      end else if (bus_in.addr == ADR_EDGE) begin
         rdata_out <= {1'b0, edge_sel};
      end else if (bus_in.addr == ADR_REQ1) begin
         rdata_out <= req[7:0];
      end else if (bus_in.addr == ADR_REQ2) begin
         rdata_out <= {1'b0, req[NSRC-1:8]};
      end else if (bus_in.addr == ADR_EN1) begin
         rdata_out <= en[7:0];
      end else if (bus_in.addr == ADR_EN2) begin
         rdata_out <= {1'b0, en[NSRC-1:8]};
      end else begin
         rdata_out <= 8'h00;
      end
   end

endmodule // icp_interrupt_controller

/* File: core/icp_pkg.sv */
package icp_pkg;

   localparam int NSRC   = 15;
   localparam int NPIN   = 7;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;

   localparam logic [ADDR_W-1:0] ADR_CTRL = 6'h38;
   localparam logic [ADDR_W-1:0] ADR_EDGE = 6'h3A;
   localparam logic [ADDR_W-1:0] ADR_REQ1 = 6'h3C;
   localparam logic [ADDR_W-1:0] ADR_REQ2 = 6'h3D;
   localparam logic [ADDR_W-1:0] ADR_EN1  = 6'h3E;
   localparam logic [ADDR_W-1:0] ADR_EN2  = 6'h3F;

   localparam logic [NSRC-1:0]   REQ_RST  = 15'h0000;
   localparam logic [NSRC-1:0]   EN_RST   = 15'h0000;
   localparam logic [NPIN-1:0]   EDGE_RST = 7'h00;
   localparam logic              IFLAG_RST = 1'b1;

   localparam logic [15:0] VEC_RESET = 16'hFFFC;
   localparam logic [15:0] VEC_FIRST = 16'hFFFA;
   localparam logic [15:0] VEC_BREAK = 16'hFFDC;

   localparam int SRC_HIF   = 0;
   localparam int SRC_HOE   = 1;
   localparam int SRC_EXT0  = 2;
   localparam int SRC_SRX   = 3;
   localparam int SRC_STX   = 4;
   localparam int SRC_TMX   = 5;
   localparam int SRC_TM1   = 6;
   localparam int SRC_TM2   = 7;
   localparam int SRC_CNTR  = 8;
   localparam int SRC_EXT1  = 9;
   localparam int SRC_KEY   = 14;
   localparam int PIN_CNTR  = 6;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } icp_bus_s;

   typedef struct packed {
      logic        valid;
      logic        push;
      logic [15:0] addr;
   } icp_vec_s;

endpackage
